//--- src/fiq_force_pkg.sv
/*
 * Constants for the fast-interrupt forcing and protect block: register
 * offsets, field positions, reset values and sizes.
 * Assumes a 32-bit AHB-Lite register bus and byte addresses below 0x200.
 */
`default_nettype none

package fiq_force_pkg;

    // Sizes
    localparam int unsigned NSRC      = 32;  // Interrupt sources, 0 is the fast one
    localparam int unsigned STK_DEPTH = 8;   // Nesting levels
    localparam int unsigned AW        = 9;   // Decoded byte address bits

    // Register byte offsets
    localparam logic [8:0] OFS_MODE0    = 9'h000;  // Source mode 0..31
    localparam logic [8:0] OFS_VEC0     = 9'h080;  // Source vector 0..31
    localparam logic [8:0] OFS_NVEC     = 9'h100;  // Normal vector register
    localparam logic [8:0] OFS_FVEC     = 9'h104;  // Fast vector register
    localparam logic [8:0] OFS_CUR      = 9'h108;  // Current status register
    localparam logic [8:0] OFS_PEND     = 9'h10C;  // Pending register
    localparam logic [8:0] OFS_MASK     = 9'h110;  // Mask state register
    localparam logic [8:0] OFS_CORE     = 9'h114;  // Core request status
    localparam logic [8:0] OFS_EN_CMD   = 9'h120;  // Enable command
    localparam logic [8:0] OFS_DIS_CMD  = 9'h124;  // Disable command
    localparam logic [8:0] OFS_CLR_CMD  = 9'h128;  // Clear command
    localparam logic [8:0] OFS_SET_CMD  = 9'h12C;  // Set command
    localparam logic [8:0] OFS_EOI_CMD  = 9'h130;  // End of interrupt
    localparam logic [8:0] OFS_SPUR     = 9'h134;  // Spurious vector
    localparam logic [8:0] OFS_DBG      = 9'h138;  // Debug control register
    localparam logic [8:0] OFS_FF_EN    = 9'h140;  // Forcing enable command
    localparam logic [8:0] OFS_FF_DIS   = 9'h144;  // Forcing disable command
    localparam logic [8:0] OFS_FF_STAT  = 9'h148;  // Forcing status register

    // Field positions
    localparam int unsigned PRIO_LSB    = 0;  // Priority, 3 bits
    localparam int unsigned STYPE_LSB   = 5;  // Source type, 2 bits
    localparam int unsigned STYPE_EDGE  = 0;  // Type bit: 1 = edge triggered
    localparam int unsigned STYPE_HIGH  = 1;  // Type bit: 1 = high / rising
    localparam int unsigned DBG_PROTECT_BIT    = 0;  // Protect bit
    localparam int unsigned DBG_GENERAL_MASK_BIT    = 1;  // General mask bit

    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  RST_DBG  = 2'h0;

endpackage : fiq_force_pkg

`default_nettype wire

//--- src/fiq_force.sv
/*
 * Fast-interrupt path of a vectored interrupt controller with fast forcing,
 * debug protect mode, a small priority selector and nesting stack, all
 * reached as a zero-wait AHB-Lite slave.
 * Assumes sources and bus are synchronous to hclk; hready is the bus ready.
 */
`default_nettype none

module fiq_force
    import fiq_force_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Interrupt sources
    input  wire logic [31:0] src_in,
    // Core request lines
    output logic             fast_request_n,
    output logic             normal_request_n
);
    import fiq_force_pkg::*;

    // Programmable state
    logic [2:0]  prio_q  [NSRC];        // Priority per source
    logic [1:0]  stype_q [NSRC];        // Source type per source
    logic [31:0] svr_q   [NSRC];        // Vector per source
    logic [31:0] spu_q;                 // Spurious vector
    logic [31:0] imr_q;                 // Enable mask
    logic [31:0] ffsr_q;                // Forcing status
    logic [31:0] pend_q, pend_d;        // Pending bits
    logic [1:0]  dbg_q;                 // Protect and general mask
    // Source sampling
    logic [31:0] smp_q;                 // Sampled sources
    logic [31:0] prev_q;                // Previous sample, edge detection
    // Nesting stack and recorded selection
    logic [2:0]  stk_lvl_q [STK_DEPTH]; // Stacked priority levels
    logic [4:0]  stk_src_q [STK_DEPTH]; // Stacked source numbers
    logic [3:0]  sp_q;                  // Stack depth in use
    logic        mem_vld_q;             // A real interrupt was recorded
    logic [4:0]  mem_src_q;             // Recorded source
    logic [2:0]  mem_lvl_q;             // Recorded level
    // Bus data phase
    logic        wph_q;                 // Write in data phase
    logic [8:0]  wadr_q;                // Its byte address
    logic [31:0] rdata_q;               // Read data register

    // Address phase decode
    wire         acc     = hsel && htrans[1] && hready;
    wire         rd_acc  = ce && acc && !hwrite;
    wire  [8:0]  aadr    = haddr[8:0];
    wire         rd_nvec = rd_acc && (aadr == OFS_NVEC);
    wire         rd_fvec = rd_acc && (aadr == OFS_FVEC);

    // Data phase write decode
    wire         wr      = ce && wph_q;
    wire         wr_mode = wr && (wadr_q < OFS_VEC0);
    wire         wr_vec  = wr && (wadr_q >= OFS_VEC0) && (wadr_q < OFS_NVEC);
    wire  [4:0]  widx    = wadr_q[6:2];
    wire         wr_nvec = wr && (wadr_q == OFS_NVEC);
    wire         wr_en   = wr && (wadr_q == OFS_EN_CMD);
    wire         wr_dis  = wr && (wadr_q == OFS_DIS_CMD);
    wire         wr_clr  = wr && (wadr_q == OFS_CLR_CMD);
    wire         wr_set  = wr && (wadr_q == OFS_SET_CMD);
    wire         wr_eoi  = wr && (wadr_q == OFS_EOI_CMD);
    wire         wr_spu  = wr && (wadr_q == OFS_SPUR);
    wire         wr_dbg  = wr && (wadr_q == OFS_DBG);
    wire         wr_ffen = wr && (wadr_q == OFS_FF_EN);
    wire         wr_ffds = wr && (wadr_q == OFS_FF_DIS);

    // Modes
    wire         protect_bit = dbg_q[DBG_PROTECT_BIT];
    wire         general_mask_bit = dbg_q[DBG_GENERAL_MASK_BIT];

    // Per-source detection, kept alive even when forced
    logic [31:0] edge_mode, act_lvl, edge_det;
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            edge_mode[i] = stype_q[i][STYPE_EDGE];
            act_lvl[i]   = stype_q[i][STYPE_HIGH] ? smp_q[i] : !smp_q[i];
            edge_det[i]  = act_lvl[i] && !(stype_q[i][STYPE_HIGH] ? prev_q[i] : !prev_q[i]);
        end
    end

    // Normal candidates exclude source 0 and forced sources
    wire  [31:0] cand = pend_q & imr_q & ~ffsr_q & 32'hFFFF_FFFE;

    // Highest priority candidate, lowest number on ties
    logic        best_fnd;
    logic [4:0]  best_idx;
    logic [2:0]  best_lvl;
    always_comb begin
        best_fnd = 1'b0;
        best_idx = 5'h0;
        best_lvl = 3'h0;
        for (int i = 1; i < NSRC; i++) begin
            if (cand[i] && (!best_fnd || prio_q[i] > best_lvl)) begin
                best_fnd = 1'b1;
                best_idx = 5'(i);
                best_lvl = prio_q[i];
            end
        end
    end

    // Current level is the stack top; empty stack accepts any level
    wire         cur_vld = (sp_q != 4'h0);
    wire  [2:0]  top     = 3'(sp_q - 4'h1);
    wire  [2:0]  cur_lvl = stk_lvl_q[top];
    wire  [4:0]  cur_src = cur_vld ? stk_src_q[top] : 5'h0;
    wire         found   = best_fnd && (!cur_vld || best_lvl > cur_lvl);

    // Acknowledge: normal read in normal mode, vector write in protect mode
    wire         ack_nrm = rd_nvec && !protect_bit && found;
    wire         ack_prt = wr_nvec && protect_bit && mem_vld_q;
    wire         push    = ack_nrm || ack_prt;
    wire  [4:0]  ack_src = ack_nrm ? best_idx : mem_src_q;
    wire  [2:0]  ack_lvl = ack_nrm ? best_lvl : mem_lvl_q;
    // Pop before push so a back-to-back end and read stay ordered
    wire         pop     = wr_eoi && cur_vld;
    wire  [3:0]  sp_pop  = pop ? sp_q - 4'h1 : sp_q;
    wire         push_ok = push && (sp_pop < 4'(STK_DEPTH));
    wire  [3:0]  sp_d    = push_ok ? sp_pop + 4'h1 : sp_pop;

    // Fast read clears source 0 only when edge triggered and no forcing
    wire         fvr_clr = rd_fvec && edge_mode[0] && (ffsr_q == RST_WORD);
    wire  [31:0] ack_one = push_ok ? (32'h0000_0001 << ack_src) : 32'h0000_0000;

    // Pending next state; a new edge beats any clear
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            if (edge_mode[i]) begin
                pend_d[i] = edge_det[i] || (wr_set && hwdata[i]) ||
                            (pend_q[i] && !(wr_clr && hwdata[i]) &&
                             !(ack_one[i] && !ffsr_q[i]) &&
                             !(i == 0 && fvr_clr));
            end else begin
                pend_d[i] = act_lvl[i];
            end
        end
    end

    // Request lines
    wire fiq_src = (pend_q[0] && imr_q[0]) || |(pend_q & imr_q & ffsr_q);
    assign fast_request_n   = !(fiq_src && !general_mask_bit);
    assign normal_request_n = !(found && !general_mask_bit);

    // Read mux
    logic [31:0] rmux;
    always_comb begin
        rmux = RST_WORD;
        if (aadr < OFS_VEC0) begin
            rmux[PRIO_LSB +: 3]  = prio_q[aadr[6:2]];
            rmux[STYPE_LSB +: 2] = stype_q[aadr[6:2]];
        end else if (aadr < OFS_NVEC) begin
            rmux = svr_q[aadr[6:2]];
        end else begin
            unique case (aadr)
                OFS_NVEC:    rmux = found ? svr_q[best_idx] : spu_q;
                OFS_FVEC:    rmux = svr_q[0];
                OFS_CUR:     rmux = {27'h0, cur_src};
                OFS_PEND:    rmux = pend_q;
                OFS_MASK:    rmux = imr_q;
                OFS_CORE:    rmux = {30'h0, !normal_request_n, !fast_request_n};
                OFS_SPUR:    rmux = spu_q;
                OFS_DBG:     rmux = {30'h0, dbg_q};
                OFS_FF_STAT: rmux = ffsr_q;
                default:     rmux = RST_WORD;   // Unmapped and write-only read zero
            endcase
        end
    end

    // Bus pipeline and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wph_q   <= 1'b0;
            wadr_q  <= 9'h000;
            rdata_q <= RST_WORD;
        end else if (ce) begin
            wph_q <= acc && hwrite;
            if (acc) wadr_q <= aadr;
            if (rd_acc) rdata_q <= rmux;
        end
    end
    assign hrdata    = rdata_q;
    assign hreadyout = 1'b1;   // Zero wait states, never stretches
    assign hresp     = 1'b0;   // Always OKAY

    // Source sampling and pending
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            smp_q  <= RST_WORD;
            prev_q <= RST_WORD;
            pend_q <= RST_WORD;
        end else if (ce) begin
            smp_q  <= src_in;
            prev_q <= smp_q;
            pend_q <= pend_d;
        end
    end

    // Per-source configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NSRC; i++) begin
                prio_q[i]  <= 3'h0;
                stype_q[i] <= 2'h0;
                svr_q[i]   <= RST_WORD;
            end
        end else if (ce) begin
            if (wr_mode) begin
                prio_q[widx]  <= hwdata[PRIO_LSB +: 3];
                stype_q[widx] <= hwdata[STYPE_LSB +: 2];
            end
            if (wr_vec) svr_q[widx] <= hwdata;
        end
    end

    // Masks, forcing, debug control, spurious vector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            imr_q  <= RST_WORD;
            ffsr_q <= RST_WORD;
            dbg_q  <= RST_DBG;
            spu_q  <= RST_WORD;
        end else if (ce) begin
            if (wr_en)   imr_q  <= imr_q | hwdata;
            if (wr_dis)  imr_q  <= imr_q & ~hwdata;
            // Bit 0 cannot be forced: it already is the fast source
            if (wr_ffen) ffsr_q <= ffsr_q | (hwdata & 32'hFFFF_FFFE);
            if (wr_ffds) ffsr_q <= ffsr_q & ~hwdata;
            if (wr_dbg)  dbg_q  <= hwdata[1:0];
            if (wr_spu)  spu_q  <= hwdata;
        end
    end

    // Recorded selection and nesting stack
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_vld_q <= 1'b0;
            mem_src_q <= 5'h0;
            mem_lvl_q <= 3'h0;
            sp_q      <= 4'h0;
            for (int i = 0; i < STK_DEPTH; i++) begin
                stk_lvl_q[i] <= 3'h0;
                stk_src_q[i] <= 5'h0;
            end
        end else if (ce) begin
            // Every normal vector read re-selects and records; only protect mode vector writes consume it
            if (rd_nvec) begin
                mem_vld_q <= found;
                mem_src_q <= best_idx;
                mem_lvl_q <= best_lvl;
            end else if (ack_prt) begin
                mem_vld_q <= 1'b0;
            end
            if (push_ok) begin
                stk_lvl_q[3'(sp_pop)] <= ack_lvl;
                stk_src_q[3'(sp_pop)] <= ack_src;
            end
            sp_q <= sp_d;
        end
    end

    // Checks
    general_mask_bit_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
        general_mask_bit |-> fast_request_n && normal_request_n)
        else $error("request line active under general mask");
    forced_fiq_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!general_mask_bit && |(pend_q & imr_q & ffsr_q)) |-> !fast_request_n)
        else $error("forced pending source did not raise fast request");
    forced_skip_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !normal_request_n |-> !ffsr_q[best_idx] && best_idx != 5'h0)
        else $error("forced or fast source raised normal request");
    fvr_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_fvec |=> hrdata == $past(svr_q[0]))
        else $error("fast vector read did not return source 0 vector");
    fvr_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (fvr_clr && !edge_det[0] && !(wr_set && hwdata[0])) |=> !pend_q[0])
        else $error("fast vector read left edge source 0 pending");
    fvr_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_fvec && edge_mode[0] && ffsr_q != RST_WORD && pend_q[0] && !wr_clr) |=> pend_q[0])
        else $error("fast vector read cleared source 0 under forcing");
    ack_forced_a: assert property (@(posedge hclk) disable iff (!hresetn)
        push_ok |-> !ffsr_q[ack_src])
        else $error("acknowledge hit a forced source");
    protect_bit_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_nvec && protect_bit && !pop && !push) |=> sp_q == $past(sp_q))
        else $error("protect mode read changed the stack");
    nrm_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_nvec && !protect_bit && !rd_nvec) |-> !push)
        else $error("normal mode vector write had an effect");
    nrm_push_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_nvec && !protect_bit && found && !pop && sp_q < 4'(STK_DEPTH))
        |=> sp_q == $past(sp_q) + 4'h1)
        else $error("normal mode read did not push");
    spur_vec_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_nvec && !found) |=> hrdata == $past(spu_q))
        else $error("spurious vector not returned");
    protect_bit_push_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_nvec && protect_bit && mem_vld_q && !pop && sp_q < 4'(STK_DEPTH))
        |=> sp_q == $past(sp_q) + 4'h1)
        else $error("protect mode write did not push");

    forced_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
        (|(ffsr_q & pend_q)) && !fast_request_n);
    protect_bit_pair_c:  cover property (@(posedge hclk) disable iff (!hresetn)
        (rd_nvec && protect_bit) ##[1:4] ack_prt);
    spur_c:       cover property (@(posedge hclk) disable iff (!hresetn) rd_nvec && !found);
    nest_c:       cover property (@(posedge hclk) disable iff (!hresetn) sp_q == 4'h2);

endmodule : fiq_force

`default_nettype wire

//--- dv/core_model.sv
/*
 * Processor-core model: AHB-Lite master for single word transfers, and the
 * receiver of the fast and normal request lines.
 * Assumes it is called just after a rising edge and that hready is hreadyout.
 */
`default_nettype none

module core_model
    import fiq_force_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite master side
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Request lines from the controller
    input  wire logic        fast_request_n,
    input  wire logic        normal_request_n
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned timeouts = 0;  // Waits that ran out of cycles

    // Bus idle at time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // One single transfer; the core keeps handler order itself
    task automatic xfer(input logic wr, input logic [8:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        int n;
        n = 0;
        hsel   <= 1'b1;
        haddr  <= {23'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        // Address phase held until ready is seen
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        if (wr) begin
            hwdata <= wd;
        end
        // Data phase held until ready is seen
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 100);
        rd = hrdata;
        // Released data lines must not keep the old value
        hwdata <= ~wd;
        if (n >= 50) begin
            timeouts++;
        end
    endtask : xfer

    // Handler entry: wait for its line, then read its vector first
    task automatic enter(input logic fast, output logic [31:0] vec);
        int n;
        n = 0;
        while ((fast ? fast_request_n : normal_request_n) !== 1'b0 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 50) begin
            timeouts++;
        end
        xfer(1'b0, fast ? OFS_FVEC : OFS_NVEC, 32'h0000_0000, vec);
    endtask : enter
endmodule : core_model

`default_nettype wire

//--- dv/test_fast_irq_forcing_and_protect.sv
/*
 * Self-checking bench for the fast-interrupt forcing and protect block.
 * Assumes the core model drives the bus and sources register in two edges.
 */
`default_nettype none

module test_fast_irq_forcing_and_protect;
    timeunit 1ns;
    timeprecision 1ps;
    import fiq_force_pkg::*;

    localparam logic [8:0] NO_WR = 9'h1FF;  // Row has no write
    localparam logic [8:0] MODE5 = 9'h014;  // Mode of source 5
    localparam logic [8:0] VEC5  = 9'h094;  // Vector of source 5
    typedef struct packed {
        logic [8:0]  wa;  // Write address or NO_WR
        logic [31:0] wd;  // Write data
        logic [8:0]  ra;  // Read-back address
        logic [31:0] ex;  // Expected read data
    } row_t;

    logic        hclk, hresetn, ce;          // Clock, reset, enable
    logic        hsel, hwrite, hready, hresp;  // Bus control
    logic [1:0]  htrans;                     // Transfer kind
    logic [2:0]  hsize;                      // Transfer size
    logic [31:0] haddr, hwdata, hrdata;      // Bus address and data
    logic [31:0] src_in;                     // Interrupt sources
    logic        fast_request_n, normal_request_n;  // Core request lines
    int          fail_count = 0;             // Mismatches
    int          n_tests = 0;                // Comparisons
    logic [31:0] vec_seen;                   // Vector taken by the handler model
    // Register table: reset values, forcing bits, mask, debug bits
    row_t rows [15] = '{
        '{NO_WR, 32'h0000_0000, OFS_FF_STAT, 32'h0000_0000},
        '{NO_WR, 32'h0000_0000, OFS_DBG, 32'h0000_0000},
        '{OFS_FF_EN, 32'hFFFF_FFFF, OFS_FF_STAT, 32'hFFFF_FFFE},
        '{OFS_FF_DIS, 32'h0000_0F00, OFS_FF_STAT, 32'hFFFF_F0FE},
        '{OFS_FF_DIS, 32'hFFFF_FFFF, OFS_FF_STAT, 32'h0000_0000},
        '{OFS_EN_CMD, 32'h0000_0001, OFS_MASK, 32'h0000_0001},
        '{OFS_DIS_CMD, 32'h0000_0001, OFS_MASK, 32'h0000_0000},
        '{OFS_DBG, 32'h0000_0001, OFS_DBG, 32'h0000_0001},
        '{OFS_DBG, 32'h0000_0000, OFS_DBG, 32'h0000_0000},
        '{NO_WR, 32'h0000_0000, 9'h118, 32'h0000_0000},
        '{OFS_VEC0, 32'h0000_1C00, OFS_FVEC, 32'h0000_1C00},
        '{OFS_SPUR, 32'h0000_0BAD, OFS_SPUR, 32'h0000_0BAD},
        '{MODE5, 32'h0000_0023, MODE5, 32'h0000_0023},
        '{OFS_SET_CMD, 32'h0000_0002, OFS_PEND, 32'h0000_0002},
        '{OFS_CLR_CMD, 32'h0000_0002, OFS_PEND, 32'h0000_0000}};

    // Single slave: its ready is the bus ready
    fiq_force i_fiq_force (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .src_in(src_in), .fast_request_n(fast_request_n),
        .normal_request_n(normal_request_n));
    core_model i_core_model (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .fast_request_n(fast_request_n),
        .normal_request_n(normal_request_n));

    // 25 MHz clock
    initial hclk = 1'b0;
    always #20 hclk = ~hclk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] ex);
        n_tests++;
        if (seen !== ex) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, ex, seen);
        end
    endtask : check

    // Lines follow registers updated at the edge: look once they settle
    task automatic req(input logic [1:0] ex);  // {fast, normal}
        @(negedge hclk);
        check("request lines", {30'h0000_0000, fast_request_n, normal_request_n},
              {30'h0000_0000, ex});
        @(posedge hclk);
    endtask : req

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] unused;
        i_core_model.xfer(1'b1, a, d, unused);
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [31:0] ex, input string what);
        logic [31:0] d;
        i_core_model.xfer(1'b0, a, 32'h0000_0000, d);
        check(what, d, ex);
    endtask : rd

    // Source change, then time for sampling and detection to land
    task automatic set_src(input int i, input logic v);
        src_in[i] <= v;
        repeat (3) @(posedge hclk);
    endtask : set_src

    task automatic end_sim();
        fail_count += int'(i_core_model.timeouts);
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // Main sequence
    initial begin
        hresetn = 1'b0;
        ce      = 1'b1;
        src_in  = 32'h0000_0000;
        repeat (9) @(posedge hclk);
        check("reset read data", hrdata, 32'h0000_0000);
        check("reset response", {31'h0000_0000, hresp}, 32'h0000_0000);
        req(2'b11);
        hresetn <= 1'b1;
        $display("test reset finished");
        // All sources rising edge, nothing left pending
        for (int i = 0; i < 32; i++) wr(OFS_MODE0 + 9'(4 * i), 32'h0000_0060);
        wr(OFS_CLR_CMD, 32'hFFFF_FFFF);
        foreach (rows[k]) begin
            if (rows[k].wa !== NO_WR) wr(rows[k].wa, rows[k].wd);
            rd(rows[k].ra, rows[k].ex, "table row");
        end
        $display("test register table finished");
        // Fast source 0, edge then level
        wr(OFS_EN_CMD, 32'h0000_0021);
        set_src(0, 1'b1);
        set_src(0, 1'b0);
        req(2'b01);
        rd(OFS_CORE, 32'h0000_0001, "core status");
        i_core_model.enter(1'b1, vec_seen);
        check("fast vector", vec_seen, 32'h0000_1C00);
        req(2'b11);
        wr(OFS_MODE0, 32'h0000_0040);
        set_src(0, 1'b1);
        rd(OFS_FVEC, 32'h0000_1C00, "level fast vector");
        req(2'b01);
        set_src(0, 1'b0);
        req(2'b11);
        wr(OFS_MODE0, 32'h0000_0060);
        $display("test fast source finished");
        // Protect mode: reads select only, the write acknowledges
        wr(MODE5, 32'h0000_0063);
        wr(VEC5, 32'h0000_5500);
        wr(OFS_DBG, 32'h0000_0001);
        set_src(5, 1'b1);
        set_src(5, 1'b0);
        req(2'b10);
        rd(OFS_NVEC, 32'h0000_5500, "protect vector");
        rd(OFS_NVEC, 32'h0000_5500, "protect vector again");
        rd(OFS_CUR, 32'h0000_0000, "status before write");
        rd(OFS_PEND, 32'h0000_0020, "pending before write");
        wr(OFS_NVEC, 32'h1234_5678);
        rd(OFS_CUR, 32'h0000_0005, "status after write");
        rd(OFS_PEND, 32'h0000_0000, "pending after write");
        req(2'b11);
        wr(OFS_EOI_CMD, 32'h0000_0000);
        wr(OFS_DBG, 32'h0000_0000);
        $display("test protect mode finished");
        // Forcing of source 5, edge then level, general mask on top
        wr(OFS_FF_EN, 32'h0000_0020);
        set_src(5, 1'b1);
        set_src(5, 1'b0);
        req(2'b01);
        rd(OFS_PEND, 32'h0000_0020, "forced pending");
        rd(OFS_FVEC, 32'h0000_1C00, "forced fast vector");
        req(2'b01);
        rd(OFS_NVEC, 32'h0000_0BAD, "forced normal read");
        rd(OFS_PEND, 32'h0000_0020, "forced after read");
        wr(OFS_DBG, 32'h0000_0002);
        req(2'b11);
        wr(OFS_DBG, 32'h0000_0000);
        wr(OFS_CLR_CMD, 32'h0000_0020);
        req(2'b11);
        wr(MODE5, 32'h0000_0043);
        set_src(5, 1'b1);
        req(2'b01);
        set_src(5, 1'b0);
        req(2'b11);
        wr(OFS_FF_DIS, 32'h0000_0020);
        wr(MODE5, 32'h0000_0063);
        $display("test forcing finished");
        // Normal mode: write ignored, read does everything
        set_src(5, 1'b1);
        set_src(5, 1'b0);
        wr(OFS_NVEC, 32'h0000_0000);
        rd(OFS_PEND, 32'h0000_0020, "pending after write");
        req(2'b10);
        i_core_model.enter(1'b0, vec_seen);
        check("normal vector", vec_seen, 32'h0000_5500);
        rd(OFS_CUR, 32'h0000_0005, "normal status");
        rd(OFS_PEND, 32'h0000_0000, "normal pending");
        req(2'b11);
        wr(OFS_EOI_CMD, 32'h0000_0000);
        $display("test normal mode finished");
        // Enable low freezes sampling: a pulse while frozen is never seen
        ce <= 1'b0;
        set_src(5, 1'b1);
        set_src(5, 1'b0);
        ce <= 1'b1;
        rd(OFS_PEND, 32'h0000_0000, "pending after freeze");
        req(2'b11);
        $display("test clock enable finished");
        // Reset in mid-run drops forcing and protect
        wr(OFS_FF_EN, 32'h0000_0020);
        wr(OFS_DBG, 32'h0000_0001);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        req(2'b11);
        hresetn <= 1'b1;
        rd(OFS_FF_STAT, 32'h0000_0000, "forcing after reset");
        rd(OFS_DBG, 32'h0000_0000, "debug after reset");
        $display("test mid-run reset finished");
        end_sim();
    end
endmodule : test_fast_irq_forcing_and_protect

`default_nettype wire
